// ===== dse_map.svh
// Constants of the differential symbol encoder.
// Functional notes
// - Enabled: output bit is current XOR previous.
// - Raw bit changed: encoded bit is one.
// - Raw bit unchanged: encoded bit is zero.
// - Bit encoding precedes symbol mapping downstream.
// - Each symbol looks up offset, steps position while offsets on.
// - Offset plus one moves one state forward.
// - Offset minus one moves one state back.
// - Offset two moves two states forward.
// - Offset zero keeps the position.
// - Symbol selects relative move while offsets on, absolute place otherwise.
// - Next position depends on previous position while offsets on.
// - Symbol width follows state count.
// - Offsets only on real-time path, not playback.
// - Separate offset table for I/Q and FSK.
// - Offsets act only while offset enable set.
// - Bit encoding off: raw bits pass unchanged.
// - Bits per symbol is ceiling log2 states.
`ifndef DSE_MAP_SVH
`define DSE_MAP_SVH
`define DSE_SYM_W       4
`define DSE_TBL_DEPTH   16
`define DSE_FIFO_DEPTH  8
`define DSE_CNT_MIN     5'h02
`define DSE_CNT_MAX     5'h10
`define DSE_POS_RESET   4'h0
`define DSE_PREV_RESET  1'b0
`define DSE_OFF_RESET   4'h0
`endif

// ===== dse_pkg.sv
// Types shared by the differential symbol encoder modules.
package dse_pkg;
   typedef logic [3:0]        dse_sym_t;
   typedef logic signed [3:0] dse_off_t;
   typedef enum logic {
      DSE_MAP_IQ  = 1'b0,
      DSE_MAP_FSK = 1'b1
   } dse_map_e;
   typedef enum logic {
      DSE_IDLE = 1'b0,
      DSE_RUN  = 1'b1
   } dse_run_e;
endpackage : dse_pkg

// ===== dse_stream_if.sv
// Valid/ready stream carrier between the encoder's internal stages.
`timescale 1ns/1ps
interface dse_stream_if #(parameter int W = 1) ();
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : dse_stream_if

// ===== dse_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module dse_fifo #(
   parameter int W = 1,
   parameter int D = 8
) (
   // Clock and control
   input wire logic    clk,
   input wire logic    rst,
   input wire logic    flush,
   // Streams
   dse_stream_if.snk   wr,
   dse_stream_if.src   rd
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem [0:D-1];
   logic [AW:0]  wp_reg;
   logic [AW:0]  rp_reg;
   logic         full;
   logic         empty;
   logic         push;
   logic         pop;

   // Extra pointer bit tells full from empty without a counter.
   assign empty    = (wp_reg == rp_reg);
   assign full     = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data  = mem[rp_reg[AW-1:0]];
   assign push     = wr.valid && !full;
   assign pop      = rd.ready && !empty;

   // Storage is written only; it needs no reset.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_reg[AW-1:0]] <= wr.data;
      end
   end

   // Pointers; a flush drops whatever a previous frame left behind.
   always_ff @(posedge clk) begin
      if (rst || flush) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else begin
         if (push) begin
            wp_reg <= wp_reg + 1'b1;
         end
         if (pop) begin
            rp_reg <= rp_reg + 1'b1;
         end
      end
   end
endmodule : dse_fifo

// ===== dse_xor_enc.sv
// Bit-transition encoder stage in front of the symbol FIFO.
`timescale 1ns/1ps
`include "dse_map.svh"
module dse_xor_enc (
   // Clock and control
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic start,
   input  wire logic enable,
   // Raw bit input
   input  wire logic in_valid,
   input  wire logic in_bit,
   output logic      in_ready,
   // Encoded bit output
   dse_stream_if.src out
);
   logic prev_reg;
   logic vld_reg;
   logic bit_reg;
   logic rdy_reg;
   logic take;
   logic vld_next;

   assign take     = in_valid && rdy_reg;
   assign vld_next = take || (vld_reg && !out.ready);
   assign in_ready = rdy_reg;
   assign out.valid = vld_reg;
   assign out.data  = bit_reg;

   // One-deep output stage; ready is a flop so the input port sees no gate,
   // at the cost of one bit every second cycle at most.
   always_ff @(posedge clk) begin
      if (rst || start) begin
         vld_reg <= 1'b0;
         rdy_reg <= 1'b1;
      end else begin
         vld_reg <= vld_next;
         rdy_reg <= !vld_next;
      end
   end

   // Encoded bit is the change between neighbours, or the raw bit when off.
   always_ff @(posedge clk) begin
      if (rst) begin
         bit_reg <= 1'b0;
      end else if (take) begin
         bit_reg <= enable ? (in_bit ^ prev_reg) : in_bit;
      end
   end

   // Previous raw bit, cleared at modulation start.
   always_ff @(posedge clk) begin
      if (rst || start) begin
         prev_reg <= `DSE_PREV_RESET;
      end else if (take) begin
         prev_reg <= in_bit;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   xor_output_a: assert property (
      take && enable && !start |=> bit_reg == ($past(in_bit) ^ $past(prev_reg)))
      else $error("Encoded bit is not the XOR of neighbours.");
   change_one_a: assert property (
      take && enable && !start && (in_bit != prev_reg) |=> out.valid && out.data)
      else $error("A changed raw bit did not give a one.");
   same_zero_a: assert property (
      take && enable && !start && (in_bit == prev_reg) |=> out.valid && !out.data)
      else $error("An unchanged raw bit did not give a zero.");
   raw_pass_a: assert property (
      take && !enable && !start |=> out.data == $past(in_bit))
      else $error("Raw bit was altered with encoding off.");
endmodule : dse_xor_enc

// ===== dse_top.sv
// Differential symbol encoder: bit-transition stage, FIFO, offset stepping.
`timescale 1ns/1ps
`include "dse_map.svh"
module dse_top (
   // Clock and reset
   input  wire logic                 CLK,
   input  wire logic                 RESET,
   // Mode control
   input  wire logic                 MOD_START,
   input  wire logic                 XOR_EN,
   input  wire logic                 OFFSET_EN,
   input  wire logic                 ARB_PLAYBACK,
   input  wire logic                 MAP_FSK,
   input  wire logic [4:0]           STATE_COUNT,
   // Offset table write port
   input  wire logic                 TBL_WE,
   input  wire logic                 TBL_FSK,
   input  wire logic [3:0]           TBL_ADDR,
   input  wire dse_pkg::dse_off_t    TBL_OFFSET,
   // Raw data input
   input  wire logic                 DIN_VALID,
   input  wire logic                 DIN_BIT,
   output logic                      DIN_READY,
   // Symbol and state output towards the mapper
   output logic                      DOUT_VALID,
   input  wire logic                 DOUT_READY,
   output dse_pkg::dse_sym_t         DOUT_SYMBOL,
   output dse_pkg::dse_sym_t         DOUT_STATE,
   output logic                      RUNNING
);
   dse_stream_if #(.W(1)) enc_if ();
   dse_stream_if #(.W(1)) fifo_if ();

   dse_pkg::dse_run_e  run_reg;
   dse_pkg::dse_off_t  tbl_reg [0:1][0:`DSE_TBL_DEPTH-1];
   logic [2:0]         cnt_reg;
   dse_pkg::dse_sym_t  shf_reg;
   dse_pkg::dse_sym_t  pos_reg;
   logic               out_valid_reg;
   dse_pkg::dse_sym_t  out_sym_reg;
   dse_pkg::dse_sym_t  out_state_reg;

   logic [4:0]         cnt_eff;
   logic [2:0]         bps;
   logic               pop;
   logic               last;
   logic               load;
   logic               offs_on;
   dse_pkg::dse_sym_t  sym_full;
   dse_pkg::dse_off_t  cur_off;
   dse_pkg::dse_sym_t  pos_next;

   // Bits are encoded before they ever reach symbol assembly.
   dse_xor_enc u_enc (
      .clk      (CLK),
      .rst      (RESET),
      .start    (MOD_START),
      .enable   (XOR_EN),
      .in_valid (DIN_VALID),
      .in_bit   (DIN_BIT),
      .in_ready (DIN_READY),
      .out      (enc_if.src)
   );

   // Elastic store between the bit stage and the symbol stage.
   dse_fifo #(
      .W (1),
      .D (`DSE_FIFO_DEPTH)
   ) u_fifo (
      .clk   (CLK),
      .rst   (RESET),
      .flush (MOD_START),
      .wr    (enc_if.snk),
      .rd    (fifo_if.src)
   );

   // Out-of-range counts are clamped so the modulo below never sees zero.
   always_comb begin
      if (STATE_COUNT < `DSE_CNT_MIN) begin
         cnt_eff = `DSE_CNT_MIN;
      end else if (STATE_COUNT > `DSE_CNT_MAX) begin
         cnt_eff = `DSE_CNT_MAX;
      end else begin
         cnt_eff = STATE_COUNT;
      end
   end

   // Bits per symbol is the ceiling of log2 of the state count.
   always_comb begin
      if (cnt_eff <= 5'h02) begin
         bps = 3'h1;
      end else if (cnt_eff <= 5'h04) begin
         bps = 3'h2;
      end else if (cnt_eff <= 5'h08) begin
         bps = 3'h3;
      end else begin
         bps = 3'h4;
      end
   end

   // Position step with wrap; the bias keeps the dividend positive.
   function automatic dse_pkg::dse_sym_t wrap_step(
      input dse_pkg::dse_sym_t pos,
      input dse_pkg::dse_off_t off,
      input logic [4:0]        cnt
   );
      int s;
      s = int'(pos) + int'(off) + 16 * int'(cnt);
      return dse_pkg::dse_sym_t'(s % int'(cnt));
   endfunction : wrap_step

   // Symbol assembly and stepping; bits arrive MSB first.
   assign offs_on       = OFFSET_EN && !ARB_PLAYBACK;
   assign fifo_if.ready = (run_reg == dse_pkg::DSE_RUN) && (!out_valid_reg || DOUT_READY);
   assign pop           = fifo_if.valid && fifo_if.ready;
   assign last          = ({1'b0, cnt_reg} + 4'h1) == {1'b0, bps};
   assign load          = pop && last && !MOD_START;
   assign sym_full      = {shf_reg[2:0], fifo_if.data[0]};
   assign cur_off       = tbl_reg[MAP_FSK][sym_full];

   // With offsets on only the move comes from the symbol; otherwise the symbol is the position.
   always_comb begin
      if (offs_on) begin
         pos_next = wrap_step(pos_reg, cur_off, cnt_eff);
      end else begin
         pos_next = sym_full;
      end
   end

   // Run state: symbols are built only after a modulation start.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         run_reg <= dse_pkg::DSE_IDLE;
      end else begin
         case (run_reg)
            dse_pkg::DSE_IDLE: begin
               if (MOD_START) begin
                  run_reg <= dse_pkg::DSE_RUN;
               end
            end
            dse_pkg::DSE_RUN: begin
               run_reg <= dse_pkg::DSE_RUN;
            end
            default: begin
               run_reg <= dse_pkg::DSE_IDLE;
            end
         endcase
      end
   end

   // Offset tables, one per user mapping kind, cleared to zero offsets.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < `DSE_TBL_DEPTH; i++) begin
               tbl_reg[m][i] <= `DSE_OFF_RESET;
            end
         end
      end else if (TBL_WE) begin
         tbl_reg[TBL_FSK][TBL_ADDR] <= TBL_OFFSET;
      end
   end

   // Bit collector for the current symbol.
   always_ff @(posedge CLK) begin
      if (RESET || MOD_START) begin
         cnt_reg <= 3'h0;
         shf_reg <= 4'h0;
      end else if (pop) begin
         if (last) begin
            cnt_reg <= 3'h0;
            shf_reg <= 4'h0;
         end else begin
            cnt_reg <= cnt_reg + 3'h1;
            shf_reg <= sym_full;
         end
      end
   end

   // Position register, returned to the first state at each start.
   always_ff @(posedge CLK) begin
      if (RESET || MOD_START) begin
         pos_reg <= `DSE_POS_RESET;
      end else if (load) begin
         pos_reg <= pos_next;
      end
   end

   // Output holding register; it stands until the mapper takes it.
   always_ff @(posedge CLK) begin
      if (RESET || MOD_START) begin
         out_valid_reg <= 1'b0;
      end else if (load) begin
         out_valid_reg <= 1'b1;
      end else if (DOUT_READY) begin
         out_valid_reg <= 1'b0;
      end
   end

   // Symbol and state words captured with each new symbol.
   always_ff @(posedge CLK) begin
      if (RESET) begin
         out_sym_reg   <= 4'h0;
         out_state_reg <= `DSE_POS_RESET;
      end else if (load) begin
         out_sym_reg   <= sym_full;
         out_state_reg <= pos_next;
      end
   end

   assign DOUT_VALID  = out_valid_reg;
   assign DOUT_SYMBOL = out_sym_reg;
   assign DOUT_STATE  = out_state_reg;
   assign RUNNING     = (run_reg == dse_pkg::DSE_RUN);

   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);

   sequence offs_load_s;
      load && offs_on;
   endsequence

   sequence plain_load_s;
      load && !offs_on;
   endsequence

   property step_by_p(logic signed [3:0] off, logic [4:0] adv);
      offs_load_s ##0 (cur_off == off) |=>
         ({1'b0, pos_reg} == (({1'b0, $past(pos_reg)} + $past(adv)) % $past(cnt_eff)));
   endproperty

   fwd_one_a: assert property (step_by_p(4'sh1, 5'h01))
      else $error("Offset plus one did not advance one state.");
   back_one_a: assert property (step_by_p(-4'sh1, cnt_eff - 5'h01))
      else $error("Offset minus one did not step back one state.");
   fwd_two_a: assert property (step_by_p(4'sh2, 5'h02))
      else $error("Offset two did not advance two states.");
   hold_zero_a: assert property (
      offs_load_s ##0 (cur_off == 4'sh0) |=> $stable(pos_reg) && DOUT_STATE == pos_reg)
      else $error("Offset zero moved the position.");
   offset_gate_a: assert property (
      plain_load_s |=> DOUT_VALID && DOUT_STATE == $past(sym_full))
      else $error("Offsets acted while disabled.");
   start_pos_a: assert property (
      MOD_START |=> pos_reg == `DSE_POS_RESET && !DOUT_VALID)
      else $error("Start did not return to the first state.");
   state_wrap_a: assert property (
      offs_load_s |=> {1'b0, pos_reg} < $past(cnt_eff))
      else $error("Position left the state map.");
   hold_out_a: assert property (
      DOUT_VALID && !DOUT_READY |=> DOUT_VALID && $stable(DOUT_STATE))
      else $error("Output dropped before it was taken.");
endmodule : dse_top

// ===== dse_partner.sv
// Behavioural model of the raw bit source and the symbol mapper around the encoder.
`timescale 1ns/1ps
module dse_partner (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Raw bit source side
   output logic                   din_valid,
   output logic                   din_bit,
   input  wire logic              din_ready,
   // Mapper side
   input  wire logic              dout_valid,
   output logic                   dout_ready,
   input  wire dse_pkg::dse_sym_t dout_symbol,
   input  wire dse_pkg::dse_sym_t dout_state,
   input  wire logic              stall
);
   logic              bit_q[$];
   dse_pkg::dse_sym_t sym_q[$];
   dse_pkg::dse_sym_t st_q[$];
   logic              taken;

   // Start idle with the data line at an arbitrary level.
   initial begin
      din_valid  = 1'b0;
      din_bit    = 1'b1;
      dout_ready = 1'b0;
      taken      = 1'b0;
   end

   // Handshakes are judged on the rising edge where the design samples them.
   always @(posedge clk) begin
      taken <= din_valid && din_ready;
      if (dout_valid && dout_ready) begin
         sym_q.push_back(dout_symbol);
         st_q.push_back(dout_state);
      end
   end

   // Requests change only after the edge that took the previous one.
   always @(negedge clk) begin
      dout_ready <= !stall;
      if (rst) begin
         din_valid <= 1'b0;
      end else if (!din_valid || taken) begin
         if (bit_q.size() > 0) begin
            din_valid <= 1'b1;
            din_bit   <= bit_q.pop_front();
         end else begin
            // An idle line toggles so that no stale bit looks valid.
            din_valid <= 1'b0;
            din_bit   <= ~din_bit;
         end
      end
   end
endmodule : dse_partner

// ===== differential_symbol_encoder_tb_top.sv
// Self-checking testbench of the differential symbol encoder.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
   $display("Error t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module differential_symbol_encoder_tb_top;
   logic              clk, reset, mod_start, xor_en, offset_en, arb_playback, map_fsk;
   logic [4:0]        state_count;
   logic              tbl_we, tbl_fsk, stall, din_valid, din_bit, din_ready;
   logic [3:0]        tbl_addr;
   dse_pkg::dse_off_t tbl_offset;
   logic              dout_valid, dout_ready, running;
   dse_pkg::dse_sym_t dout_symbol, dout_state;
   int                error_cnt, check_count;
   int                tbl[2][16];

   dse_top uut (.CLK(clk), .RESET(reset), .MOD_START(mod_start), .XOR_EN(xor_en),
      .OFFSET_EN(offset_en), .ARB_PLAYBACK(arb_playback), .MAP_FSK(map_fsk),
      .STATE_COUNT(state_count), .TBL_WE(tbl_we), .TBL_FSK(tbl_fsk), .TBL_ADDR(tbl_addr),
      .TBL_OFFSET(tbl_offset), .DIN_VALID(din_valid), .DIN_BIT(din_bit),
      .DIN_READY(din_ready), .DOUT_VALID(dout_valid), .DOUT_READY(dout_ready),
      .DOUT_SYMBOL(dout_symbol), .DOUT_STATE(dout_state), .RUNNING(running));

   dse_partner p (.clk(clk), .rst(reset), .din_valid(din_valid), .din_bit(din_bit),
      .din_ready(din_ready), .dout_valid(dout_valid), .dout_ready(dout_ready),
      .dout_symbol(dout_symbol), .dout_state(dout_state), .stall(stall));

   // Free-running 10 MHz clock.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop

   // Writes one table entry and keeps the expected copy in step.
   task automatic wr_tbl(input logic fs, input logic [3:0] a, input int off);
      @(negedge clk);
      tbl_we     = 1'b1;
      tbl_fsk    = fs;
      tbl_addr   = a;
      tbl_offset = dse_pkg::dse_off_t'(off);
      tbl[fs][a] = off;
      @(negedge clk);
      tbl_we = 1'b0;
   endtask : wr_tbl

   // Starts modulation, feeds bits first-left and compares every symbol and state.
   task automatic run_case(input logic xe, input logic oe, input logic pb, input logic fs,
                           input logic [4:0] cnt, input logic [31:0] bits, input int n,
                           input logic stall_on);
      int                bps, pos, k, w;
      logic              prev, e;
      logic [3:0]        sym;
      dse_pkg::dse_sym_t exp_sym[$], exp_st[$];
      for (bps = 1; (1 << bps) < cnt; bps++);
      @(negedge clk);
      xor_en       = xe;
      offset_en    = oe;
      arb_playback = pb;
      map_fsk      = fs;
      state_count  = cnt;
      stall        = stall_on;
      mod_start    = 1'b1;
      @(negedge clk);
      mod_start = 1'b0;
      p.sym_q.delete();
      p.st_q.delete();
      prev = 1'b0;
      pos  = 0;
      sym  = 4'h0;
      for (k = 0; k < n; k++) begin
         e    = xe ? (bits[n-1-k] ^ prev) : bits[n-1-k];
         prev = bits[n-1-k];
         sym  = {sym[2:0], e};
         p.bit_q.push_back(bits[n-1-k]);
         if ((k + 1) % bps == 0) begin
            if (oe && !pb) pos = ((pos + tbl[fs][sym]) % int'(cnt) + int'(cnt)) % int'(cnt);
            else pos = sym;
            exp_sym.push_back(sym);
            exp_st.push_back(4'(pos));
            sym = 4'h0;
         end
      end
      if (stall_on) begin
         repeat (60) @(negedge clk);
         `CHK(din_ready, 1'b0)
         `CHK(dout_valid, 1'b1)
         stall = 1'b0;
      end
      for (w = 0; w < 2000 && p.sym_q.size() < exp_sym.size(); w++) @(negedge clk);
      `CHK(p.sym_q.size(), exp_sym.size())
      for (k = 0; k < exp_sym.size() && k < p.sym_q.size(); k++) begin
         `CHK(p.sym_q[k], exp_sym[k])
         `CHK(p.st_q[k], exp_st[k])
      end
      `CHK(running, 1'b1)
   endtask : run_case

   // Values right after reset.
   task automatic t_reset;
      `CHK(din_ready, 1'b1)
      `CHK(dout_valid, 1'b0)
      `CHK(dout_state, 4'h0)
      `CHK(running, 1'b0)
   endtask : t_reset

   // Transition encoding of an alternating and repeating stream.
   task automatic t_xor;
      run_case(1, 0, 0, 0, 5'h04, 32'h000014CA, 14, 0);
   endtask : t_xor

   // Encoding off: raw bits reach the mapper, one bit per symbol.
   task automatic t_raw;
      run_case(0, 0, 0, 0, 5'h02, 32'h000000B3, 8, 0);
   endtask : t_raw

   // Offsets +1, -1, +2 and 0 on a four-state map.
   task automatic t_iq;
      wr_tbl(0, 4'h0, 1);
      wr_tbl(0, 4'h1, -1);
      wr_tbl(0, 4'h2, 2);
      wr_tbl(0, 4'h3, 0);
      run_case(0, 1, 0, 0, 5'h04, 32'h000000E1, 10, 0);
      run_case(1, 1, 0, 0, 5'h04, 32'h000000E1, 10, 0);
   endtask : t_iq

   // Separate FSK table, wrap on eight states, mapper stalled until the FIFO refuses.
   task automatic t_fsk;
      int offs[8] = '{1, -3, 7, -8, 0, 2, -1, 5};
      int i;
      for (i = 0; i < 8; i++) wr_tbl(1, 4'(i), offs[i]);
      run_case(0, 1, 0, 1, 5'h08, 32'h00A72C5B, 24, 1);
   endtask : t_fsk

   // Playback path and disabled offsets give plain mapping; five states need three bits.
   task automatic t_plain;
      run_case(0, 1, 1, 0, 5'h10, 32'h0000C3A5, 16, 0);
      run_case(0, 0, 0, 0, 5'h05, 32'h00000E29, 12, 0);
   endtask : t_plain

   // Inputs set at time zero and changed only on falling edges.
   initial begin
      {mod_start, xor_en, offset_en, arb_playback, map_fsk} = 5'h00;
      {tbl_we, tbl_fsk, stall} = 3'h0;
      state_count = 5'h04;
      tbl_addr    = 4'h0;
      tbl_offset  = 4'sh0;
      error_cnt   = 0;
      check_count = 0;
      tbl         = '{default: 0};
      reset       = 1'b1;
      repeat (10) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      t_reset();
      t_xor();
      t_raw();
      t_iq();
      t_fsk();
      t_plain();
      report_and_stop();
   end

   // Cuts a hang short well after the expected run of a few hundred cycles.
   initial begin
      #2000000;
      error_cnt++;
      report_and_stop();
   end
endmodule : differential_symbol_encoder_tb_top
